// ---- gpx_map.vh ----
// Pointer codes, reset values and bus constants of the 16-bit GPIO expander
`ifndef GPX_MAP_VH
`define GPX_MAP_VH

// ==========================================================
// Pointer codes (one per 8-bit register, bank 0 even, bank 1 odd, except drive: DRV0-DRV1 bank 0, DRV2-DRV3 bank 1, and ODEN for both banks)
`define GPX_REG_IN0 5'h00
`define GPX_REG_IN1 5'h01
`define GPX_REG_OUT0 5'h02
`define GPX_REG_OUT1 5'h03
`define GPX_REG_POL0 5'h04
`define GPX_REG_POL1 5'h05
`define GPX_REG_CFG0 5'h06
`define GPX_REG_CFG1 5'h07
`define GPX_REG_DRV0 5'h08
`define GPX_REG_DRV3 5'h0B
`define GPX_REG_LAT0 5'h0C
`define GPX_REG_PEN0 5'h0E
`define GPX_REG_PSEL0 5'h10
`define GPX_REG_MASK0 5'h12
`define GPX_REG_STAT0 5'h14
`define GPX_REG_STAT1 5'h15
`define GPX_REG_ODEN 5'h16
`define GPX_REG_LAST 5'h16

// ==========================================================
// Reset values
`define GPX_RST_OUT 8'hFF
`define GPX_RST_CFG 8'hFF
`define GPX_RST_DRV 8'hFF
`define GPX_RST_PSEL 8'hFF
`define GPX_RST_MASK 8'hFF
`define GPX_RST_ZERO 8'h00

// ==========================================================
// Slave address: fixed upper five bits, two strap bits below
`define GPX_ADDR_BASE 5'h1D

`endif

// ---- gpx_expander.v ----
// 16-bit two-wire GPIO expander: serial slave, register file, port pins, interrupt
// Notes on behaviour
// R1: All pin interrupts are masked after reset.
// R2: Interrupt pulled low while an unmasked input differs from its input register.
// R3: Reset pin low holds all registers and the bus engine at defaults.
// R4: Power-on reset loads defaults before any bus transfer is accepted.
// R5: Slave address takes two strap bits, four devices per bus.
// R6: After reset every port pin is a released, undriven input.
// R7: Each bank has configuration, input, output and polarity registers.
// R8: Each bank selects push-pull or open-drain output stages.
// R9: Read-only status register shows which inputs raise the interrupt.
// R10: Each bit holds a two-bit drive strength, four levels.
// R11: Latched input change is held until the input register is read.
// R12: Each bit has pull enable and separate pull-up/down select.
// R13: A set mask bit stops that input from raising the interrupt.
// R14: Last address bit high means read, low means write.
// R15: First byte after address sets the write-only pointer.
// R16: Interrupt releases on input register read or inputs returning.
`include "gpx_map.vh"

module gpx_expander #(
  parameter NBITS = 16
) (
  // Clock and resets
  input wire clk,
  input wire sys_rst,
  input wire reset_pin_n,
  // Address straps
  input wire addr_select_lsb,
  input wire addr_select_msb,
  // Serial bus
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_ff,
  output reg sda_oe_n_ff,
  // Port pins
  input wire [NBITS-1:0] pin_in,
  output reg [NBITS-1:0] pin_out_ff,
  output reg [NBITS-1:0] pin_oe_n_ff,
  // Pad settings
  output reg [2*NBITS-1:0] drive_str_ff,
  output reg [NBITS-1:0] pull_en_ff,
  output reg [NBITS-1:0] pull_up_ff,
  // Interrupt, open-drain
  output reg int_out_ff,
  output reg int_oe_n_ff
);

  localparam ST_IDLE = 4'h1;
  localparam ST_ADDR = 4'h2;
  localparam ST_WR = 4'h4;
  localparam ST_RD = 4'h8;

  // ==========================================================
  // Reset and input sampling
  wire rst = sys_rst | ~reset_pin_n; // see R3 see R4
  reg [2:0] scl_sync_ff;
  reg [2:0] sda_sync_ff;
  reg [NBITS-1:0] pin_s1_ff;
  reg [NBITS-1:0] pin_s2_ff;
  always @(posedge clk) begin
    scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
    sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
    pin_s1_ff <= pin_in;
    pin_s2_ff <= pin_s1_ff;
  end
  // Only stages 1 and 2 are looked at, stage 0 feeds stage 1 alone
  wire scl_rise = scl_sync_ff[1] & ~scl_sync_ff[2];
  wire scl_fall = ~scl_sync_ff[1] & scl_sync_ff[2];
  wire bus_start = scl_sync_ff[1] & scl_sync_ff[2] & ~sda_sync_ff[1] & sda_sync_ff[2];
  wire bus_stop = scl_sync_ff[1] & scl_sync_ff[2] & sda_sync_ff[1] & ~sda_sync_ff[2];
  // ==========================================================
  // Register file
  reg [7:0] regs_ff [0:`GPX_REG_LAST];
  wire [NBITS-1:0] outv = {regs_ff[`GPX_REG_OUT1], regs_ff[`GPX_REG_OUT0]};
  wire [NBITS-1:0] polv = {regs_ff[`GPX_REG_POL1], regs_ff[`GPX_REG_POL0]};
  wire [NBITS-1:0] cfgv = {regs_ff[`GPX_REG_CFG1], regs_ff[`GPX_REG_CFG0]};
  wire [NBITS-1:0] latv = {regs_ff[`GPX_REG_LAT0 + 5'h01], regs_ff[`GPX_REG_LAT0]};
  wire [NBITS-1:0] maskv = {regs_ff[`GPX_REG_MASK0 + 5'h01], regs_ff[`GPX_REG_MASK0]};
  function [7:0] rst_val;
    input [4:0] idx;
    begin
      case (idx)
        `GPX_REG_OUT0, `GPX_REG_OUT1: rst_val = `GPX_RST_OUT;
        `GPX_REG_CFG0, `GPX_REG_CFG1: rst_val = `GPX_RST_CFG; // see R6
        `GPX_REG_PSEL0, `GPX_REG_PSEL0 + 5'h01: rst_val = `GPX_RST_PSEL;
        `GPX_REG_MASK0, `GPX_REG_MASK0 + 5'h01: rst_val = `GPX_RST_MASK; // see R1
        default: begin
          if (idx >= `GPX_REG_DRV0 && idx <= `GPX_REG_DRV3) begin
            rst_val = `GPX_RST_DRV;
          end else begin
            rst_val = `GPX_RST_ZERO;
          end
        end
      endcase
    end
  endfunction
  // Input and status registers are not storage, writes to them are dropped
  function writable;
    input [4:0] idx;
    begin
      writable = (idx >= `GPX_REG_OUT0) && (idx <= `GPX_REG_LAST) &&
                 (idx != `GPX_REG_STAT0) && (idx != `GPX_REG_STAT1);
    end
  endfunction

  // ==========================================================
  // Per-bit input tracking
  reg [1:0] in_rd_ff; // pulse per bank when its input register is loaded for reading
  wire [NBITS-1:0] in_val;
  wire [NBITS-1:0] chg;
  genvar gi;
  generate
    for (gi = 0; gi < NBITS; gi = gi + 1) begin : g_bit
      reg snap_ff;
      reg hold_ff;
      reg held_ff;
      wire live = pin_s2_ff[gi] ^ polv[gi]; // see R7
      always @(posedge clk) begin
        if (rst) begin
          snap_ff <= live;
          hold_ff <= 1'b0;
          held_ff <= 1'b0;
        end else if (in_rd_ff[gi/8]) begin
          snap_ff <= live; // see R16
          hold_ff <= 1'b0;
          held_ff <= live;
        end else if (latv[gi] && !hold_ff && live != snap_ff) begin
          hold_ff <= 1'b1; // see R11
          held_ff <= live;
        end
      end
      assign in_val[gi] = hold_ff ? held_ff : live; // see R11
      assign chg[gi] = hold_ff | (live != snap_ff); // see R2 see R16
    end
  endgenerate
  // Status registered once, interrupt one cycle later
  reg [NBITS-1:0] stat_ff;
  always @(posedge clk) begin
    if (rst) begin
      stat_ff <= {NBITS{1'b0}};
      int_oe_n_ff <= 1'b1;
      int_out_ff <= 1'b0;
    end else begin
      stat_ff <= chg & ~maskv; // see R9 see R13
      int_oe_n_ff <= ~|stat_ff; // see R2
      int_out_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Pin and pad drivers
  wire [1:0] od_bank = regs_ff[`GPX_REG_ODEN][1:0];
  integer k;
  always @(posedge clk) begin
    if (rst) begin
      pin_out_ff <= {NBITS{1'b0}};
      pin_oe_n_ff <= {NBITS{1'b1}}; // see R6
      drive_str_ff <= {2*NBITS{1'b1}};
      pull_en_ff <= {NBITS{1'b0}};
      pull_up_ff <= {NBITS{1'b1}};
    end else begin
      for (k = 0; k < NBITS; k = k + 1) begin
        pin_out_ff[k] <= outv[k];
        // Open-drain bank only pulls low, a one lets the pin float
        pin_oe_n_ff[k] <= cfgv[k] | (od_bank[k/8] & outv[k]); // see R8
        pull_en_ff[k] <= regs_ff[`GPX_REG_PEN0 + k/8][k%8]; // see R12
        pull_up_ff[k] <= regs_ff[`GPX_REG_PSEL0 + k/8][k%8]; // see R12
        drive_str_ff[2*k +: 2] <= regs_ff[`GPX_REG_DRV0 + k/4][2*(k%4) +: 2]; // see R10
      end
    end
  end

  // ==========================================================
  // Serial slave engine
  reg [3:0] st_ff;
  reg [3:0] cnt_ff;
  reg [7:0] sh_ff;
  reg [4:0] ptr_ff;
  reg first_ff;
  reg nack_ff;
  wire [6:0] my_addr = {`GPX_ADDR_BASE, addr_select_msb, addr_select_lsb}; // see R5
  function [7:0] rd_byte;
    input [4:0] idx;
    begin
      case (idx)
        `GPX_REG_IN0: rd_byte = in_val[7:0];
        `GPX_REG_IN1: rd_byte = in_val[15:8];
        `GPX_REG_STAT0: rd_byte = stat_ff[7:0]; // see R9
        `GPX_REG_STAT1: rd_byte = stat_ff[15:8];
        default: rd_byte = (idx <= `GPX_REG_LAST) ? regs_ff[idx] : 8'h00;
      endcase
    end
  endfunction
  // Auto-increment stays inside the register pair
  wire [4:0] nxt_ptr = ptr_ff ^ 5'h01;
  wire [7:0] rd_cur = rd_byte(ptr_ff);
  wire [7:0] rd_nxt = rd_byte(nxt_ptr);
  integer j;
  always @(posedge clk) begin
    if (rst) begin
      st_ff <= ST_IDLE; // see R3 see R4
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      ptr_ff <= 5'h00;
      first_ff <= 1'b0;
      nack_ff <= 1'b0;
      sda_out_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
      in_rd_ff <= 2'h0;
      for (j = 0; j <= `GPX_REG_LAST; j = j + 1) begin
        regs_ff[j] <= rst_val(j[4:0]);
      end
    end else begin
      in_rd_ff <= 2'h0;
      sda_out_ff <= 1'b0;
      if (bus_start) begin
        st_ff <= ST_ADDR;
        cnt_ff <= 4'h0;
        sda_oe_n_ff <= 1'b1;
      end else if (bus_stop) begin
        st_ff <= ST_IDLE;
        sda_oe_n_ff <= 1'b1;
      end else if (scl_rise && st_ff != ST_IDLE) begin
        if (cnt_ff < 4'h8) begin
          sh_ff <= {sh_ff[6:0], sda_sync_ff[1]};
        end else begin
          nack_ff <= sda_sync_ff[1];
        end
        cnt_ff <= cnt_ff + 4'h1;
      end else if (scl_fall) begin
        case (st_ff)
          ST_ADDR: begin
            if (cnt_ff == 4'h8) begin
              if (sh_ff[7:1] == my_addr) begin
                sda_oe_n_ff <= 1'b0;
              end else begin
                st_ff <= ST_IDLE;
              end
            end else if (cnt_ff == 4'h9) begin
              cnt_ff <= 4'h0;
              first_ff <= 1'b1;
              if (sh_ff[0]) begin // see R14
                st_ff <= ST_RD;
                sh_ff <= rd_cur;
                sda_oe_n_ff <= rd_cur[7];
                if (ptr_ff == `GPX_REG_IN0 || ptr_ff == `GPX_REG_IN1) begin
                  in_rd_ff[ptr_ff[0]] <= 1'b1;
                end
              end else begin
                st_ff <= ST_WR;
                sda_oe_n_ff <= 1'b1;
              end
            end
          end
          ST_WR: begin
            if (cnt_ff == 4'h8) begin
              sda_oe_n_ff <= 1'b0;
              first_ff <= 1'b0;
              if (first_ff) begin
                ptr_ff <= sh_ff[4:0]; // see R15
              end else begin
                if (writable(ptr_ff)) begin
                  regs_ff[ptr_ff] <= sh_ff;
                end
                ptr_ff <= nxt_ptr;
              end
            end else if (cnt_ff == 4'h9) begin
              sda_oe_n_ff <= 1'b1;
              cnt_ff <= 4'h0;
            end
          end
          ST_RD: begin
            if (cnt_ff < 4'h8) begin
              sda_oe_n_ff <= sh_ff[7]; // Each rise moved the next bit up
            end else if (cnt_ff == 4'h8) begin
              sda_oe_n_ff <= 1'b1;
            end else if (nack_ff) begin
              st_ff <= ST_IDLE;
            end else begin
              cnt_ff <= 4'h0;
              ptr_ff <= nxt_ptr;
              sh_ff <= rd_nxt;
              sda_oe_n_ff <= rd_nxt[7];
              if (nxt_ptr == `GPX_REG_IN0 || nxt_ptr == `GPX_REG_IN1) begin
                in_rd_ff[nxt_ptr[0]] <= 1'b1; // see R16
              end
            end
          end
          default: begin
            sda_oe_n_ff <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

// ---- gpx_monitor.sv ----
// Port checker for the GPIO expander
module gpx_monitor #(parameter NBITS = 16) (
  // Clock and resets
  input wire clk,
  input wire sys_rst,
  input wire reset_pin_n,
  // Watched ports
  input wire scl_in,
  input wire sda_out_ff,
  input wire sda_oe_n_ff,
  input wire [NBITS-1:0] pin_oe_n_ff,
  input wire [2*NBITS-1:0] drive_str_ff,
  input wire [NBITS-1:0] pull_en_ff,
  input wire [NBITS-1:0] pull_up_ff,
  input wire int_out_ff,
  input wire int_oe_n_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Helpers and properties
  wire rst = sys_rst || !reset_pin_n;
  wire dflt = (&pin_oe_n_ff) && int_oe_n_ff && sda_oe_n_ff && !(|pull_en_ff) &&
    (&drive_str_ff) && (&pull_up_ff);
  logic [8:0] age_ff;
  // No bus write can finish this soon after reset
  always @(posedge clk) begin
    if (rst) age_ff <= 9'h000;
    else if (age_ff != 9'h1FF) age_ff <= age_ff + 9'h001;
  end
  property p_por;
    @(posedge clk) disable iff (!reset_pin_n) sys_rst |=> dflt;
  endproperty
  a_por: assert property (p_por) else $error("defaults lost in power-on reset");
  property p_pin_rst;
    @(posedge clk) disable iff (sys_rst) !reset_pin_n |=> dflt;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("defaults lost in pin reset");
  property p_masked;
    @(posedge clk) disable iff (rst) (age_ff < 9'h0FA) |-> int_oe_n_ff;
  endproperty
  a_masked: assert property (p_masked) else $error("interrupt before unmask");
  property p_inputs;
    @(posedge clk) disable iff (rst) (age_ff < 9'h0FA) |-> (&pin_oe_n_ff);
  endproperty
  a_inputs: assert property (p_inputs) else $error("pin driven after reset");
  property p_sda_low;
    @(posedge clk) disable iff (rst) $changed(sda_oe_n_ff) |-> !scl_in;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda moved while scl high");
  property p_od;
    @(posedge clk) disable iff (rst) !sda_out_ff && !int_out_ff;
  endproperty
  a_od: assert property (p_od) else $error("open-drain line driven high");
  property p_cfg;
    @(posedge clk) disable iff (rst) $changed(pin_oe_n_ff) |->
      !(sda_oe_n_ff && $past(sda_oe_n_ff) && $past(sda_oe_n_ff, 2));
  endproperty
  a_cfg: assert property (p_cfg) else $error("direction moved without write");
  property p_pad;
    @(posedge clk) disable iff (rst)
      ($changed(drive_str_ff) || $changed(pull_en_ff) || $changed(pull_up_ff)) |->
      !(sda_oe_n_ff && $past(sda_oe_n_ff) && $past(sda_oe_n_ff, 2));
  endproperty
  a_pad: assert property (p_pad) else $error("pad setting moved without write");
  c_int: cover property (@(posedge clk) disable iff (rst) $fell(int_oe_n_ff));
  c_ack: cover property (@(posedge clk) disable iff (rst) $fell(sda_oe_n_ff));
  c_cfg: cover property (@(posedge clk) disable iff (rst) $changed(pin_oe_n_ff));
endmodule
bind gpx_expander gpx_monitor #(.NBITS(NBITS)) u_mon (.clk(clk), .sys_rst(sys_rst),
  .reset_pin_n(reset_pin_n), .scl_in(scl_in), .sda_out_ff(sda_out_ff),
  .sda_oe_n_ff(sda_oe_n_ff), .pin_oe_n_ff(pin_oe_n_ff), .drive_str_ff(drive_str_ff),
  .pull_en_ff(pull_en_ff), .pull_up_ff(pull_up_ff), .int_out_ff(int_out_ff),
  .int_oe_n_ff(int_oe_n_ff));

// ---- gpx_i2c_host.sv ----
// Two-wire bus master model for the expander
module gpx_i2c_host (
  // Clock
  input wire clk,
  // Bus
  input wire sda_oe_n,
  output logic scl_o,
  output wire sda_o,
  // Results
  output logic [7:0] res,
  output logic res_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Bit and byte engine
  logic sda_drv = 1'b1;
  // Pull-up wins whenever both sides release
  assign sda_o = sda_drv & sda_oe_n;
  initial begin
    scl_o = 1'b1;
    res = 8'h00;
    res_valid = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    tick(4);
    scl_o <= 1'b1;
    tick(6);
    r = sda_o;
    scl_o <= 1'b0;
    tick(4);
  endtask
  task automatic note(input logic [7:0] v);
    res <= v;
    res_valid <= 1'b1;
    tick(1);
    res_valid <= 1'b0;
  endtask
  // Start when stp is 0, stop when 1
  task automatic cond(input logic stp);
    sda_drv <= !stp;
    tick(4);
    scl_o <= 1'b1;
    tick(6);
    sda_drv <= stp;
    tick(6);
    if (!stp) scl_o <= 1'b0;
    tick(4);
  endtask
  task automatic put(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, a);
  endtask
  task automatic wr(input logic [6:0] adr, input logic [7:0] p, input logic [7:0] d);
    logic a;
    cond(1'b0);
    put({adr, 1'b0}, a);
    note({7'h00, a});
    if (!a) begin
      put(p, a);
      put(d, a);
    end
    cond(1'b1);
  endtask
  task automatic rd(input logic [6:0] adr, input logic [7:0] p);
    logic a;
    logic [7:0] d;
    cond(1'b0);
    put({adr, 1'b0}, a);
    note({7'h00, a});
    put(p, a);
    cond(1'b0);
    put({adr, 1'b1}, a);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, a);
    note(d);
    cond(1'b1);
  endtask
endmodule

// ---- gpx_expander_tb_top.sv ----
// Self-checking bench for the GPIO expander
`include "gpx_map.vh"
module gpx_expander_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals and helpers
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_pin_n = 1'b1;
  logic addr_select_lsb = 1'b0;
  logic addr_select_msb = 1'b0;
  logic [15:0] pin_in = 16'h0000;
  wire scl, sda, sda_out, sda_oe_n, int_out, int_oe_n, res_valid;
  wire [15:0] pin_out, pin_oe_n, pull_en, pull_up;
  wire [31:0] drive;
  wire [7:0] res;
  logic [7:0] exp_q[$];
  int err_total = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h0000001A;
  logic [31:0] rnd;
  logic [6:0] adr;
  initial begin
    forever #5 clk = ~clk;
  end
  gpx_expander u_dut (.clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
    .addr_select_lsb(addr_select_lsb), .addr_select_msb(addr_select_msb), .scl_in(scl),
    .sda_in(sda), .sda_out_ff(sda_out), .sda_oe_n_ff(sda_oe_n), .pin_in(pin_in),
    .pin_out_ff(pin_out), .pin_oe_n_ff(pin_oe_n), .drive_str_ff(drive), .pull_en_ff(pull_en),
    .pull_up_ff(pull_up), .int_out_ff(int_out), .int_oe_n_ff(int_oe_n));
  gpx_i2c_host u_host (.clk(clk), .sda_oe_n(sda_oe_n), .scl_o(scl), .sda_o(sda), .res(res),
    .res_valid(res_valid));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] dflt(input logic [4:0] p);
    return (p < 5'h04 || (p > 5'h05 && p < 5'h0C) || p > 5'h0F) ? 8'hFF : 8'h00;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic w(input logic [4:0] p, input logic [7:0] d);
    exp_q.push_back(8'h00);
    u_host.wr(adr, {3'h0, p}, d);
    tick(3);
  endtask
  task automatic r(input logic [4:0] p, input logic [7:0] e);
    exp_q.push_back(8'h00);
    exp_q.push_back(e);
    u_host.rd(adr, {3'h0, p});
    tick(3);
  endtask
  task automatic port_dflt();
    chk("pin_oe_n", 32'h0000FFFF, 32'(pin_oe_n));
    chk("int_oe_n", 32'h1, 32'(int_oe_n));
    chk("drive", 32'hFFFFFFFF, drive);
    chk("pull", 32'h0000FFFF, {pull_en, pull_up});
    chk("od_out", 32'h0, 32'({sda_out, int_out}));
  endtask
  // ==========================================================
  // Result watcher; an empty queue can never match 9 bits
  always @(posedge clk) begin
    if (res_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("result", 32'h100, 32'(res));
      else chk("result", 32'(exp_q.pop_front()), 32'(res));
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    $display("mismatch run_time expected end seen timeout");
    stop_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    tick(8);
    rnd = xs();
    addr_select_lsb <= rnd[0];
    addr_select_msb <= rnd[1];
    adr = {`GPX_ADDR_BASE, rnd[1], rnd[0]};
    sys_rst <= 1'b0;
    tick(4);
    port_dflt();
    exp_q.push_back(8'h01);
    u_host.wr(adr ^ 7'h01, 8'h02, 8'h00);
    for (logic [4:0] p = 5'h02; p < 5'h14; p++) r(p, dflt(p));
    rnd = xs();
    w(`GPX_REG_CFG0, 8'h00);
    w(`GPX_REG_OUT0, rnd[7:0]);
    chk("pin_oe_n", 32'h0000FF00, 32'(pin_oe_n));
    chk("pin_out", 32'(rnd[7:0]), 32'(pin_out[7:0]));
    w(`GPX_REG_ODEN, 8'h01);
    chk("pin_oe_n", 32'(rnd[7:0]), 32'(pin_oe_n[7:0]));
    w(`GPX_REG_DRV0, rnd[15:8]);
    chk("drive", 32'(rnd[15:8]), 32'(drive[7:0]));
    w(`GPX_REG_PEN0, rnd[23:16]);
    w(`GPX_REG_PSEL0, rnd[31:24]);
    chk("pull_en", 32'(rnd[23:16]), 32'(pull_en[7:0]));
    chk("pull_up", 32'(rnd[31:24]), 32'(pull_up[7:0]));
    pin_in[8] <= 1'b1;
    tick(10);
    chk("int_oe_n", 32'h1, 32'(int_oe_n));
    w(`GPX_REG_MASK0 + 5'h01, 8'hFE);
    chk("int_oe_n", 32'h0, 32'(int_oe_n));
    r(`GPX_REG_STAT1, 8'h01);
    r(`GPX_REG_IN1, 8'h01);
    chk("int_oe_n", 32'h1, 32'(int_oe_n));
    w(`GPX_REG_POL1, 8'h01);
    chk("int_oe_n", 32'h0, 32'(int_oe_n));
    w(`GPX_REG_POL1, 8'h00);
    chk("int_oe_n", 32'h1, 32'(int_oe_n));
    w(`GPX_REG_LAT0 + 5'h01, 8'h01);
    pin_in[8] <= 1'b0;
    tick(6);
    pin_in[8] <= 1'b1;
    tick(6);
    chk("int_oe_n", 32'h0, 32'(int_oe_n));
    r(`GPX_REG_IN1, 8'h00);
    chk("int_oe_n", 32'h1, 32'(int_oe_n));
    reset_pin_n <= 1'b0;
    tick(4);
    port_dflt();
    reset_pin_n <= 1'b1;
    tick(4);
    r(`GPX_REG_MASK0 + 5'h01, 8'hFF);
    r(`GPX_REG_CFG0, 8'hFF);
    chk("queue", 32'h0, 32'(exp_q.size()));
    stop_test();
  end
endmodule
